// ==== asm_pkg.sv ====
// asm_pkg: register map, control field layout and reset values for the
// strobe-register serial master port. assumes nothing beyond a sv-2012 compiler.
`default_nettype none
package asm_pkg;

  localparam logic [31:0] ADDR_SHIFT_DATA     = 32'h800000d0;
  localparam logic [31:0] ADDR_SERIAL_CONTROL = 32'h800000d4;
  localparam logic [31:0] ADDR_CLOCK_PRESCALER = 32'h800000d8;
  localparam logic [31:0] ADDR_SLAVE_SELECT   = 32'h800000dc;

  // serial_control field positions
  localparam int CTL_GO      = 0;
  localparam int CTL_RX_NEG  = 1;
  localparam int CTL_TX_NEG  = 2;
  localparam int CTL_LEN_LO  = 3;
  localparam int CTL_LEN_HI  = 7;
  localparam int CTL_LSB     = 8;
  localparam int CTL_IE      = 9;
  localparam int CTL_POL     = 10;
  localparam int CTL_LOOP    = 11;
  localparam int CTL_W       = 12;

  localparam int LEN_W = 5;
  localparam int DIV_W = 16;
  localparam int SEL_W = 2;
  localparam int CNT_W = 6;

  localparam logic [CTL_W-1:0] CTL_RST  = 12'h000;
  localparam logic [DIV_W-1:0] DIV_RST  = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RST  = 2'h0;
  localparam logic [31:0]      DATA_RST = 32'h00000000;
  localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } asm_state_t;

endpackage
`default_nettype wire

// ==== asm_prescaler.sv ====
// asm_prescaler: 16-bit down-counter producing one tick per half period
// of the serial clock. assumes a single core clock and active-low reset.
`timescale 1ns/1ns
`default_nettype none
module asm_prescaler (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_run,
  input  wire logic [asm_pkg::DIV_W-1:0] i_div,
  output logic                          o_tick
);
  import asm_pkg::*;

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  wire              at_zero = (cnt_r == DIV_ZERO);

  // reload on zero: setting 0 ticks every cycle, giving core clock / 2
  assign cnt_nxt = !i_run ? i_div : (at_zero ? i_div : cnt_r - 16'h0001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= DIV_RST;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= i_run && at_zero;
    end
  end
endmodule
`default_nettype wire

// ==== asm_top.sv ====
// asm_top: serial master port with register access over a simple
// documented-register strobe port. assumes all inputs except the
// master-in pin are on the core clock; the pin is synchronised here.
`timescale 1ns/1ns
`default_nettype none
module asm_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [31:0] I_REG_ADDR,
  input  wire logic        I_REG_SEL,
  input  wire logic        I_REG_WRITE,
  input  wire logic [31:0] I_REG_WDATA,
  output logic      [31:0] O_REG_RDATA,
  input  wire logic        I_MISO,
  output logic             O_MOSI,
  output logic             O_SCLK,
  output logic [asm_pkg::SEL_W-1:0] O_SLAVE_SEL,
  output logic             O_IRQ,
  output logic             O_BUSY
);
  import asm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register access decode
  wire acc     = I_REG_SEL;
  wire wr      = acc && I_REG_WRITE;
  wire rd      = acc && !I_REG_WRITE;
  wire hit_dat = (I_REG_ADDR == ADDR_SHIFT_DATA);
  wire hit_ctl = (I_REG_ADDR == ADDR_SERIAL_CONTROL);
  wire hit_div = (I_REG_ADDR == ADDR_CLOCK_PRESCALER);
  wire hit_sel = (I_REG_ADDR == ADDR_SLAVE_SELECT);

  asm_state_t       state_r;
  asm_state_t       state_nxt;
  logic [31:0]      shift_word_r;
  logic [31:0]      shift_word_nxt;
  logic [CTL_W-1:0] ctl_r;
  logic [CTL_W-1:0] ctl_nxt;
  logic [DIV_W-1:0] div_r;
  logic [SEL_W-1:0] sel_r;
  logic [CNT_W-1:0] bits_r;
  logic [CNT_W-1:0] bits_nxt;
  logic             sclk_r;
  logic             irq_r;
  logic             mosi_r;
  logic [31:0]      rdata_nxt;
  logic             miso_s1_r;
  logic             miso_s2_r;
  logic             miso_s3_r;
  logic             miso_q_r;
  logic             tick;

  wire             shifting = (state_r == ST_SHIFT);
  wire             go       = ctl_r[CTL_GO];
  wire             rx_neg   = ctl_r[CTL_RX_NEG];
  wire             tx_neg   = ctl_r[CTL_TX_NEG];
  wire             lsb_1st  = ctl_r[CTL_LSB];
  wire             irq_en   = ctl_r[CTL_IE];
  wire             pol      = ctl_r[CTL_POL];
  wire             loop_en  = ctl_r[CTL_LOOP];
  wire [LEN_W-1:0] len_fld  = ctl_r[CTL_LEN_HI:CTL_LEN_LO];
  // field value plus one gives the bit count, 1 to 32
  wire [CNT_W-1:0] len_bits = {1'b0, len_fld} + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////
  // serial clock generation, core clock only
  asm_prescaler u_presc (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_run   (shifting),
    .i_div   (div_r),
    .o_tick  (tick)
  );

  // edges of the internal (uninverted) serial clock
  wire rise_edge = shifting && tick && !sclk_r;
  wire fall_edge = shifting && tick && sclk_r;
  wire tx_edge   = tx_neg ? fall_edge : rise_edge;
  wire rx_edge   = rx_neg ? fall_edge : rise_edge;
  // the final receive edge ends the transfer; no half period follows it
  wire last_bit  = (bits_r == CNT_ONE);
  wire finish    = rx_edge && last_bit;

  ////////////////////////////////////////////////////////////////////////
  // shift path: the data register is the shift register
  wire [LEN_W-1:0] top_idx = len_fld;
  wire       tx_bit  = lsb_1st ? shift_word_r[0]
                               : shift_word_r[top_idx];
  // loopback replaces the pin with the inverted transmit stream
  wire       rx_bit  = loop_en ? !mosi_r : miso_q_r;

  // shifting by one: msb first moves toward bit len-1, lsb first toward 0
  logic [31:0] shifted;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_sh
      wire in_len = (g <= len_fld);
      wire top    = (g == len_fld);
      wire from_lo = (g == 0) ? rx_bit : shift_word_r[(g == 0) ? 0 : g-1];
      wire from_hi = top ? rx_bit : shift_word_r[(g == 31) ? 31 : g+1];
      assign shifted[g] = !in_len ? shift_word_r[g]
                        : (lsb_1st ? from_hi : from_lo);
    end
  endgenerate

  always_comb begin
    shift_word_nxt = shift_word_r;
    if (wr && hit_dat && !shifting) begin
      shift_word_nxt = I_REG_WDATA;
    end else if (rx_edge) begin
      shift_word_nxt = shifted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb begin
    state_nxt = state_r;
    bits_nxt  = bits_r;
    ctl_nxt   = ctl_r;
    if (wr && hit_ctl && !shifting) begin
      ctl_nxt = I_REG_WDATA[CTL_W-1:0];
    end
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_SHIFT;
          bits_nxt  = len_bits;
        end
      end
      ST_SHIFT: begin
        if (rx_edge) begin
          bits_nxt = bits_r - CNT_ONE;
        end
        if (finish) begin
          state_nxt       = ST_DONE;
        end
      end
      ST_DONE: begin
        ctl_nxt[CTL_GO] = 1'b0;
        state_nxt       = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // reads show block state; unmapped and write-only reads return zero
  always_comb begin
    if (!rd) begin
      rdata_nxt = O_REG_RDATA;
    end else if (hit_dat) begin
      rdata_nxt = shift_word_r;
    end else if (hit_ctl) begin
      rdata_nxt = {20'h00000, ctl_r};
    end else if (hit_div) begin
      rdata_nxt = {16'h0000, div_r};
    end else begin
      rdata_nxt = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r      <= ST_IDLE;
      shift_word_r <= DATA_RST;
      ctl_r        <= CTL_RST;
      bits_r       <= CNT_ZERO;
    end else begin
      state_r      <= state_nxt;
      shift_word_r <= shift_word_nxt;
      ctl_r        <= ctl_nxt;
      bits_r       <= bits_nxt;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_r <= DIV_RST;
      sel_r <= SEL_RST;
    end else begin
      if (wr && hit_div && !shifting) begin
        div_r <= I_REG_WDATA[DIV_W-1:0];
      end
      if (wr && hit_sel) begin
        sel_r <= I_REG_WDATA[SEL_W-1:0];
      end
    end
  end

  // serial clock toggles only while shifting, rests low when idle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_r <= 1'b0;
    end else if (!shifting) begin
      sclk_r <= 1'b0;
    end else if (tick) begin
      sclk_r <= !sclk_r;
    end
  end

  // first bit presented at go so receive-edge sampling sees it; with
  // both edge selects equal the next bit follows the receive edge
  wire same_edge = (tx_neg == rx_neg);
  wire next_bit  = lsb_1st ? shifted[0] : shifted[top_idx];
  wire load_go   = (state_r == ST_IDLE) && go;
  wire mosi_nxt  = load_go                 ? tx_bit
                 : (tx_edge && !same_edge) ? tx_bit
                 : (rx_edge && same_edge)  ? next_bit
                 : mosi_r;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mosi_r <= 1'b0;
    end else begin
      mosi_r <= mosi_nxt;
    end
  end

  // three-stage pin synchroniser, change taken when stages 2 and 3 agree
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      miso_s3_r <= 1'b0;
      miso_q_r  <= 1'b0;
    end else begin
      miso_s1_r <= I_MISO;
      miso_s2_r <= miso_s1_r;
      miso_s3_r <= miso_s2_r;
      if (miso_s2_r == miso_s3_r) begin
        miso_q_r <= miso_s3_r;
      end
    end
  end

  // any access clears; a completion in the same cycle still wins
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_r <= 1'b0;
    end else if (state_r == ST_DONE && irq_en) begin
      irq_r <= 1'b1;
    end else if (acc) begin
      irq_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= DATA_RST;
      O_IRQ       <= 1'b0;
      O_BUSY      <= 1'b0;
    end else begin
      O_REG_RDATA <= rdata_nxt;
      O_IRQ       <= irq_r;
      O_BUSY      <= shifting || go;
    end
  end

  // link pins share one register stage so clock and data stay aligned
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_MOSI      <= 1'b0;
      O_SCLK      <= 1'b0;
      O_SLAVE_SEL <= SEL_RST;
    end else begin
      O_MOSI      <= mosi_r;
      O_SCLK      <= sclk_r ^ pol;
      O_SLAVE_SEL <= sel_r;
    end
  end
endmodule
`default_nettype wire

// ==== asm_slave_model.sv ====
// asm_slave_model: behavioural serial slave with an 8-bit reply.
// assumes its reply launches on the rising edge, mosi sampled on falling.
`timescale 1ns/1ns
`default_nettype none
module asm_slave_model #(
  parameter logic [7:0] REPLY = 8'hb1
) (
  input  wire logic       i_sclk,
  input  wire logic       i_inv,
  input  wire logic       i_sel,
  input  wire logic       i_mosi,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  wire logic  clk_i = i_sclk ^ i_inv;
  logic [7:0] sh_r;
  logic       bit_r = 1'b0;
  // released line shows the inverse, so a stale bit cannot pass
  assign o_miso = i_sel ? bit_r : ~bit_r;
  always @(posedge i_sel) sh_r <= REPLY;
  always @(posedge clk_i) begin
    if (i_sel) begin
      bit_r <= sh_r[7];
      sh_r  <= {sh_r[6:0], 1'b0};
    end
  end
  always @(negedge clk_i) if (i_sel) o_rx <= {o_rx[6:0], i_mosi};
endmodule
`default_nettype wire

// ==== asm_top_props.sv ====
// asm_top_props: port-level checks for the serial master port.
// assumes it is bound onto asm_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module asm_top_props (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_N,
  input wire logic [31:0] I_REG_ADDR,
  input wire logic        I_REG_SEL,
  input wire logic        I_REG_WRITE,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic        I_MISO,
  input wire logic        O_MOSI,
  input wire logic        O_SCLK,
  input wire logic [asm_pkg::SEL_W-1:0] O_SLAVE_SEL,
  input wire logic        O_IRQ,
  input wire logic        O_BUSY
);
  import asm_pkg::*;
  wire logic             rd_a  = I_REG_SEL && !I_REG_WRITE;
  wire logic             wr_a  = I_REG_SEL && I_REG_WRITE;
  wire logic             wr_ss = wr_a && I_REG_ADDR == ADDR_SLAVE_SELECT;
  wire logic             go_a  = wr_a && I_REG_WDATA[CTL_GO] &&
                                 I_REG_ADDR == ADDR_SERIAL_CONTROL;
  // four quiet cycles let the output flops settle after any access
  wire logic             quiet = !O_BUSY && !I_REG_SEL;
  wire logic [SEL_W-1:0] wsel  = I_REG_WDATA[SEL_W-1:0];
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////////////////////////////////
  AST_SEL: assert property (wr_ss |-> ##2 O_SLAVE_SEL == $past(wsel, 2))
    else $error("select pins");
  AST_IRQ_CLR: assert property (I_REG_SEL && !O_BUSY |-> ##[1:2] !O_IRQ)
    else $error("irq not cleared");
  AST_IRQ_SRC: assert property ($rose(O_IRQ) |-> $past(O_BUSY, 2))
    else $error("irq without transfer");
  AST_GO: assert property (go_a && !O_BUSY |-> ##[1:2] O_BUSY)
    else $error("go ignored");
  AST_END: assert property ($rose(O_BUSY) |-> ##[1:1000] !O_BUSY)
    else $error("transfer hangs");
  AST_SCLK: assert property (quiet [*4] |-> $stable(O_SCLK))
    else $error("sclk moves idle");
  AST_MOSI: assert property (quiet [*4] |-> $stable(O_MOSI))
    else $error("mosi moves idle");
  AST_RDH: assert property (!$past(rd_a) |-> $stable(O_REG_RDATA))
    else $error("read data moved");
  CV_XFER: cover property ($rose(O_BUSY));
  CV_IRQ: cover property ($rose(O_IRQ));
  CV_SS: cover property (wr_ss ##2 O_SLAVE_SEL == '1);
endmodule
bind asm_top asm_top_props i_asm_top_props (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_SEL(I_REG_SEL), .I_REG_WRITE(I_REG_WRITE),
  .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .I_MISO(I_MISO),
  .O_MOSI(O_MOSI), .O_SCLK(O_SCLK), .O_SLAVE_SEL(O_SLAVE_SEL),
  .O_IRQ(O_IRQ), .O_BUSY(O_BUSY));
`default_nettype wire

// ==== asm_top_tb_top.sv ====
// asm_top_tb_top: register-level bench for the serial master port.
// assumes package, design, slave model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module asm_top_tb_top;
  import asm_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [31:0]      ad = 32'h0;
  logic [31:0]      wd = 32'h0;
  logic             sel = 1'b0;
  logic             we = 1'b0;
  logic             inv = 1'b0;
  wire logic [31:0] rdat;
  wire logic        miso, mosi, sclk, irq, busy;
  wire logic [1:0]  ss;
  wire logic [7:0]  srx;
  logic [31:0]      v, m;
  int               h;
  int               num_errors = 0;
  int               samples_checked = 0;
  // last two entries use equal edge selects, both falling and both rising
  localparam logic [31:0] LC [5] = '{32'ha02, 32'h9fa, 32'ha7a, 32'h926,
                                     32'ha10};
  localparam logic [31:0] LD [5] = '{32'hfffffff0, 32'h87654321,
                                     32'hdeadbeef, 32'h0000005a,
                                     32'h0f0f0f0f};
  localparam logic [31:0] SD [2] = '{32'h123456b1, 32'h1234568d};
  localparam logic [7:0]  SR [2] = '{8'h9a, 8'h59};
  initial forever #5 clk = ~clk;
  asm_top i_asm_top (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(ad),
    .I_REG_SEL(sel), .I_REG_WRITE(we), .I_REG_WDATA(wd), .O_REG_RDATA(rdat),
    .I_MISO(miso), .O_MOSI(mosi), .O_SCLK(sclk), .O_SLAVE_SEL(ss),
    .O_IRQ(irq), .O_BUSY(busy));
  asm_slave_model i_asm_slave_model (.i_sclk(sclk), .i_inv(inv),
    .i_sel(ss[0]), .i_mosi(mosi), .o_miso(miso), .o_rx(srx));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // one access per call; the idle cycle after keeps strobes apart
  task automatic acc(input logic w, input logic [31:0] a, d);
    @(negedge clk);
    {we, ad, wd, sel} = {w, a, d, 1'b1};
    @(negedge clk);
    sel = 1'b0;
    @(negedge clk);
    v = rdat;
  endtask
  task automatic xfer(input logic [31:0] c);
    int   t0;
    int   n;
    logic s;
    acc(1'b1, ADDR_SERIAL_CONTROL, c);
    acc(1'b1, ADDR_SERIAL_CONTROL, c | 32'h1);
    chk("busy", 32'h1, {31'h0, busy});
    t0 = -1;
    h = -1;
    s = sclk;
    for (n = 0; n < 2000 && (n < 3 || busy === 1'b1); n++) begin
      @(negedge clk);
      if (sclk !== s && t0 >= 0 && h < 0) h = n - t0;
      if (sclk !== s && t0 < 0) t0 = n;
      s = sclk;
    end
    if (n == 2000) begin
      num_errors++;
      results();
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    // every reset value is zero; dc is write-only, e0 unmapped
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, ADDR_SHIFT_DATA + 32'(4 * i), 32'h0);
      chk("reset", 32'h0, v);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, ADDR_SLAVE_SELECT, 32'(i));
      chk("sel", 32'(i), {30'h0, ss});
    end
    acc(1'b1, ADDR_SLAVE_SELECT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ADDR_SHIFT_DATA, LD[i]);
      xfer(LC[i]);
      chk("half", 32'h1, 32'(h));
      chk("irq", {31'h0, LC[i][CTL_IE]}, {31'h0, irq});
      acc(1'b0, ADDR_SHIFT_DATA, 32'h0);
      m = 32'((64'h1 << (LC[i][CTL_LEN_HI:CTL_LEN_LO] + 1)) - 1);
      chk("loop", LD[i] ^ m, v);
      chk("irqclr", 32'h0, {31'h0, irq});
      acc(1'b0, ADDR_SERIAL_CONTROL, 32'h0);
      chk("go", LC[i], v);
    end
    // slow clock leaves room for the input synchroniser lag
    inv = 1'b1;
    acc(1'b1, ADDR_CLOCK_PRESCALER, 32'h8);
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, ADDR_SHIFT_DATA, 32'h1234569a);
      acc(1'b1, ADDR_SLAVE_SELECT, 32'h1);
      xfer(32'h43a | 32'(i << CTL_LSB));
      chk("half", 32'h9, 32'(h));
      chk("idle", 32'h1, {31'h0, sclk});
      chk("mosi", {24'h0, SR[i]}, {24'h0, srx});
      acc(1'b0, ADDR_SHIFT_DATA, 32'h0);
      chk("miso", SD[i], v);
      acc(1'b1, ADDR_SLAVE_SELECT, 32'h0);
    end
    results();
  end
endmodule
`default_nettype wire
